// ### design/rtcsi_pkg.sv
package rtcsi_pkg;

    // =========================================================
    // register offsets
    localparam logic [3:0] RTCSI_ADDR_CS1 = 4'h0;
    localparam logic [3:0] RTCSI_ADDR_CS2 = 4'h1;
    localparam logic [3:0] RTCSI_ADDR_SEC = 4'h2;

    // =========================================================
    // field positions
    localparam int RTCSI_CS1_TEST_BIT = 7;
    localparam int RTCSI_CS1_STOP_BIT = 5;
    localparam int RTCSI_CS1_POR_BIT = 3;
    localparam int RTCSI_CS2_PULSE_BIT = 4;
    localparam int RTCSI_CS2_AF_BIT = 3;
    localparam int RTCSI_CS2_TF_BIT = 2;
    localparam int RTCSI_CS2_AIE_BIT = 1;
    localparam int RTCSI_CS2_TIE_BIT = 0;
    localparam int RTCSI_SEC_VL_BIT = 7;

    // =========================================================
    // reset values
    localparam logic RTCSI_TEST_RST = 1'b0;
    localparam logic RTCSI_STOP_RST = 1'b0;
    localparam logic RTCSI_POR_RST = 1'b1;
    localparam logic RTCSI_PULSE_RST = 1'b0;
    localparam logic RTCSI_FLAG_RST = 1'b0;
    localparam logic RTCSI_IE_RST = 1'b0;
    localparam logic RTCSI_VL_RST = 1'b1;
    localparam logic [6:0] RTCSI_SEC_RST = 7'h00;

    // =========================================================
    // time base: divider counts 32768 source edges per second
    localparam int RTCSI_DIV_W = 15;
    localparam logic [14:0] RTCSI_DIV_MAX = 15'h7FFF;
    localparam logic [3:0] RTCSI_UNITS_MAX = 4'h9;
    localparam logic [2:0] RTCSI_TENS_MAX = 3'h5;

    // =========================================================
    // timing
    localparam int RTCSI_CLK_PERIOD_NS = 5;
    localparam int RTCSI_OSC_STOP_NS = 100000;
    localparam int RTCSI_OSC_STOP_CYC =
        RTCSI_OSC_STOP_NS / RTCSI_CLK_PERIOD_NS;

    // pulse lengths in 32768 Hz source edges
    localparam int RTCSI_PLS_W = 10;
    localparam logic [9:0] RTCSI_PLS_FAST_ONE = 10'h004;
    localparam logic [9:0] RTCSI_PLS_FAST = 10'h008;
    localparam logic [9:0] RTCSI_PLS_MID_ONE = 10'h100;
    localparam logic [9:0] RTCSI_PLS_SLOW = 10'h200;

    typedef enum logic [1:0]
    {
        RTCSI_SRC_4096 = 2'h0,
        RTCSI_SRC_64 = 2'h1,
        RTCSI_SRC_1 = 2'h2,
        RTCSI_SRC_60TH = 2'h3
    } rtcsi_src_e;

    function automatic logic [9:0] rtcsi_pulse_len(
        input logic [1:0] src,
        input logic [7:0] count
    );
        logic one;
        one = (count == 8'h01);
        case (rtcsi_src_e'(src))
            RTCSI_SRC_4096: rtcsi_pulse_len =
                one ? RTCSI_PLS_FAST_ONE : RTCSI_PLS_FAST;
            RTCSI_SRC_64: rtcsi_pulse_len =
                one ? RTCSI_PLS_MID_ONE : RTCSI_PLS_SLOW;
            default: rtcsi_pulse_len = RTCSI_PLS_SLOW;
        endcase
    endfunction

endpackage

// ### design/rtcsi_pulse_if.sv
`timescale 1ns/1ps
interface rtcsi_pulse_if;
    logic start;
    logic tick;
    logic [9:0] len;
    logic active;
    modport ctl (output start, output tick, output len, input active);
    modport gen (input start, input tick, input len, output active);
endinterface

// ### design/rtcsi_pulse.sv
`timescale 1ns/1ps
module rtcsi_pulse
    import rtcsi_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // pulse request and state
    rtcsi_pulse_if.gen pls
);

    typedef enum logic [0:0]
    {
        RTCSI_PLS_IDLE = 1'b0,
        RTCSI_PLS_RUN = 1'b1
    } rtcsi_pls_e;

    rtcsi_pls_e state_reg;
    logic [9:0] cnt_reg;

    // =========================================================
    // pulse timer, counts divider edges
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            state_reg <= RTCSI_PLS_IDLE;
            cnt_reg <= 10'h000;
        end
        else
        begin
            case (state_reg)
                RTCSI_PLS_IDLE:
                begin
                    if (pls.start)
                    begin
                        state_reg <= RTCSI_PLS_RUN;
                        cnt_reg <= pls.len - 10'h001;
                    end
                end
                RTCSI_PLS_RUN:
                begin
                    // a new timer end restarts the width
                    if (pls.start)
                        cnt_reg <= pls.len - 10'h001;
                    else if (pls.tick)
                    begin
                        if (cnt_reg == 10'h000)
                            state_reg <= RTCSI_PLS_IDLE;
                        else
                            cnt_reg <= cnt_reg - 10'h001;
                    end
                end
                default:
                    state_reg <= RTCSI_PLS_IDLE;
            endcase
        end
    end

    assign pls.active = (state_reg == RTCSI_PLS_RUN);

    // =========================================================
    // checks
    start_to_run_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) pls.start |=> pls.active)
        else $error("pulse did not start");

endmodule

// ### design/rtcsi_top.sv
`timescale 1ns/1ps
module rtcsi_top
    import rtcsi_pkg::*;
#(
    parameter int OSC_STOP_CYCLES = RTCSI_OSC_STOP_CYC
)
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // pins from outside the clock domain
    input wire logic i_osc_in,
    input wire logic i_external_clock_test_test,
    input wire logic i_supply_low,
    // byte register port behind the serial interface
    input wire logic i_acc_busy,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // alarm and countdown timer
    input wire logic i_alarm_match,
    input wire logic i_timer_end,
    input wire logic [1:0] i_timer_src,
    input wire logic [7:0] i_timer_count,
    // time and control outputs
    output logic o_minute_carry,
    output logic o_por_override_en,
    // open-drain pins
    output logic o_int_n_o,
    output logic o_int_n_oe_n,
    output logic o_square_wave_out_o,
    output logic o_square_wave_out_oe_n
);

    localparam int WD_W = $clog2(OSC_STOP_CYCLES + 1);

    function automatic logic wr_hit(
        input logic wr,
        input logic [3:0] addr,
        input logic [3:0] target
    );
        wr_hit = wr && (addr == target);
    endfunction

    // =========================================================
    // pin synchronisers: osc, ext clock, supply low
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [2:0] pin_prev_reg;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
            pin_prev_reg <= 3'h0;
        end
        else
        begin
            pin_meta_reg <= {i_supply_low, i_external_clock_test_test, i_osc_in};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    logic osc_rise;
    logic osc_edge;
    logic ext_rise;
    assign osc_rise = pin_sync_reg[0] && !pin_prev_reg[0];
    assign osc_edge = pin_sync_reg[0] != pin_prev_reg[0];
    assign ext_rise = pin_sync_reg[1] && !pin_prev_reg[1];

    // =========================================================
    // control one
    logic test_mode_select_reg;
    logic stop_reg;
    logic por_override_enable_reg;
    logic wr_cs1;
    logic wr_cs2;
    logic wr_sec;
    assign wr_cs1 = wr_hit(i_reg_wr, i_reg_addr, RTCSI_ADDR_CS1);
    assign wr_cs2 = wr_hit(i_reg_wr, i_reg_addr, RTCSI_ADDR_CS2);
    assign wr_sec = wr_hit(i_reg_wr, i_reg_addr, RTCSI_ADDR_SEC);

    // unused bits are dropped, so a careless host changes nothing
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            test_mode_select_reg <= RTCSI_TEST_RST;
            stop_reg <= RTCSI_STOP_RST;
            por_override_enable_reg <= RTCSI_POR_RST;
        end
        else if (wr_cs1)
        begin
            test_mode_select_reg <= i_reg_wdata[RTCSI_CS1_TEST_BIT];
            stop_reg <= i_reg_wdata[RTCSI_CS1_STOP_BIT];
            por_override_enable_reg <= i_reg_wdata[RTCSI_CS1_POR_BIT];
        end
    end

    assign o_por_override_en = por_override_enable_reg;

    // =========================================================
    // divider chain
    logic src_rise;
    logic [RTCSI_DIV_W-1:0] div_reg;
    logic sec_tick;

    assign src_rise = test_mode_select_reg ? ext_rise : osc_rise;
    assign sec_tick = src_rise && !stop_reg && (div_reg == RTCSI_DIV_MAX);

    // halt wins over any edge in the same cycle
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || stop_reg)
            div_reg <= '0;
        else if (src_rise)
            div_reg <= div_reg + 15'h0001;
    end

    // square wave follows the oscillator even while halted
    assign o_square_wave_out_o = 1'b0;
    assign o_square_wave_out_oe_n = pin_sync_reg[0];

    // =========================================================
    // oscillator watchdog
    logic [WD_W-1:0] wd_cnt_reg;
    logic osc_stopped;
    assign osc_stopped = (wd_cnt_reg == WD_W'(OSC_STOP_CYCLES));

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || osc_edge)
            wd_cnt_reg <= '0;
        else if (!osc_stopped)
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end

    // =========================================================
    // voltage-low flag and seconds
    logic vl_set;
    logic voltage_low_flag_reg;
    logic [2:0] sec_tens_reg;
    logic [3:0] sec_units_reg;
    logic pend_reg;
    logic sec_service;

    assign vl_set = pin_sync_reg[2] || osc_stopped;

    // detection wins over a clearing write
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            voltage_low_flag_reg <= RTCSI_VL_RST;
        else if (vl_set)
            voltage_low_flag_reg <= 1'b1;
        else if (wr_sec)
            voltage_low_flag_reg <= i_reg_wdata[RTCSI_SEC_VL_BIT];
    end

    // only one second can wait; access beyond a second loses time
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || stop_reg)
            pend_reg <= 1'b0;
        else
            pend_reg <= sec_tick || (pend_reg && i_acc_busy);
    end

    assign sec_service = pend_reg && !i_acc_busy;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            {sec_tens_reg, sec_units_reg} <= RTCSI_SEC_RST;
            o_minute_carry <= 1'b0;
        end
        else
        begin
            o_minute_carry <= 1'b0;
            if (wr_sec)
                {sec_tens_reg, sec_units_reg} <= i_reg_wdata[6:0];
            else if (sec_service)
            begin
                if (sec_units_reg != RTCSI_UNITS_MAX)
                    sec_units_reg <= sec_units_reg + 4'h1;
                else
                begin
                    sec_units_reg <= 4'h0;
                    if (sec_tens_reg != RTCSI_TENS_MAX)
                        sec_tens_reg <= sec_tens_reg + 3'h1;
                    else
                    begin
                        sec_tens_reg <= 3'h0;
                        o_minute_carry <= 1'b1;
                    end
                end
            end
        end
    end

    // =========================================================
    // control two: flags and enables
    logic irq_pulse_mode_reg;
    logic alarm_flag_reg;
    logic timer_flag_reg;
    logic alarm_irq_enable_reg;
    logic timer_irq_enable_reg;
    logic timer_ev;

    assign timer_ev = i_timer_end && (i_timer_count != 8'h00);

    // an event in the write cycle wins over the clear
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            alarm_flag_reg <= RTCSI_FLAG_RST;
            timer_flag_reg <= RTCSI_FLAG_RST;
        end
        else
        begin
            alarm_flag_reg <= i_alarm_match || (alarm_flag_reg &&
                (!wr_cs2 || i_reg_wdata[RTCSI_CS2_AF_BIT]));
            timer_flag_reg <= timer_ev || (timer_flag_reg &&
                (!wr_cs2 || i_reg_wdata[RTCSI_CS2_TF_BIT]));
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            irq_pulse_mode_reg <= RTCSI_PULSE_RST;
            alarm_irq_enable_reg <= RTCSI_IE_RST;
            timer_irq_enable_reg <= RTCSI_IE_RST;
        end
        else if (wr_cs2)
        begin
            irq_pulse_mode_reg <= i_reg_wdata[RTCSI_CS2_PULSE_BIT];
            alarm_irq_enable_reg <= i_reg_wdata[RTCSI_CS2_AIE_BIT];
            timer_irq_enable_reg <= i_reg_wdata[RTCSI_CS2_TIE_BIT];
        end
    end

    // =========================================================
    // register read
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
            o_reg_rdata <= 8'h00;
        else if (i_reg_rd)
        begin
            o_reg_rdata <= 8'h00;
            case (i_reg_addr)
                RTCSI_ADDR_CS1:
                begin
                    o_reg_rdata[RTCSI_CS1_TEST_BIT] <= test_mode_select_reg;
                    o_reg_rdata[RTCSI_CS1_STOP_BIT] <= stop_reg;
                    o_reg_rdata[RTCSI_CS1_POR_BIT] <= por_override_enable_reg;
                end
                RTCSI_ADDR_CS2:
                begin
                    o_reg_rdata[RTCSI_CS2_PULSE_BIT] <= irq_pulse_mode_reg;
                    o_reg_rdata[RTCSI_CS2_AF_BIT] <= alarm_flag_reg;
                    o_reg_rdata[RTCSI_CS2_TF_BIT] <= timer_flag_reg;
                    o_reg_rdata[RTCSI_CS2_AIE_BIT] <= alarm_irq_enable_reg;
                    o_reg_rdata[RTCSI_CS2_TIE_BIT] <= timer_irq_enable_reg;
                end
                RTCSI_ADDR_SEC:
                    o_reg_rdata <= {voltage_low_flag_reg, sec_tens_reg,
                        sec_units_reg};
                default:
                    o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // =========================================================
    // interrupt pulse and output
    rtcsi_pulse_if pls_if ();

    assign pls_if.start = timer_ev && irq_pulse_mode_reg;
    assign pls_if.tick = src_rise;
    assign pls_if.len = rtcsi_pulse_len(i_timer_src, i_timer_count);

    rtcsi_pulse u_pulse (
        .i_core_clk (i_core_clk),
        .i_rst_n (i_rst_n),
        .pls (pls_if.gen)
    );

    logic alarm_cond;
    logic timer_cond;
    logic irq;
    assign alarm_cond = alarm_flag_reg && alarm_irq_enable_reg;
    assign timer_cond = timer_irq_enable_reg && (irq_pulse_mode_reg ?
        pls_if.active : timer_flag_reg);
    assign irq = alarm_cond || timer_cond;

    assign o_int_n_o = 1'b0;
    assign o_int_n_oe_n = !irq;

    // =========================================================
    // checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence pulse_req_s;
        pls_if.start && timer_irq_enable_reg;
    endsequence
    sequence pulse_hold_s;
        !o_int_n_oe_n [*8];
    endsequence

    halt_clears_div_a: assert property (stop_reg |=> div_reg == '0)
        else $error("divider not cleared while halted");
    alarm_hold_a: assert property (alarm_cond |-> !o_int_n_oe_n)
        else $error("alarm interrupt released");
    alarm_set_a: assert property (i_alarm_match |=> alarm_flag_reg)
        else $error("alarm flag not set");
    flag_and_a: assert property (wr_cs2 && !timer_ev |=>
        timer_flag_reg == $past(timer_flag_reg && i_reg_wdata[2]))
        else $error("timer flag write not anded");
    af_read_a: assert property (i_reg_rd && i_reg_addr ==
        RTCSI_ADDR_CS2 |=> o_reg_rdata[3] == $past(alarm_flag_reg))
        else $error("alarm flag read mismatch");
    pulse_width_a: assert property (pulse_req_s |=> pulse_hold_s)
        else $error("interrupt pulse too short");
    zero_count_a: assert property (i_timer_end && i_timer_count == 8'h00
        && !timer_flag_reg && !wr_cs2 |=> !timer_flag_reg)
        else $error("timer flag set with zero count");
    vl_set_a: assert property (vl_set |=> voltage_low_flag_reg)
        else $error("voltage low flag not set");
    sec_frozen_a: assert property (i_acc_busy && !wr_sec |=>
        $stable(sec_units_reg) && $stable(sec_tens_reg))
        else $error("seconds moved during access");
    level_mode_a: assert property (!irq_pulse_mode_reg &&
        timer_irq_enable_reg && timer_flag_reg |-> !o_int_n_oe_n)
        else $error("level interrupt missing");
    pulse_flag_a: assert property (pulse_req_s |=> timer_flag_reg &&
        !o_int_n_oe_n)
        else $error("flag and pulse not together");

endmodule

// ### tb/rtcsi_host.sv
`timescale 1ns/1ps
module rtcsi_host
    import rtcsi_pkg::*;
(
    // clock
    input wire logic i_core_clk,
    // byte register port
    input wire logic [7:0] i_reg_rdata,
    output logic o_acc_busy,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [3:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    initial
    begin
        o_acc_busy = 1'b0;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 4'h0;
        o_reg_wdata = 8'h00;
    end

    // =========================================================
    // unused control bits leave the host as zero while a write is driven, and as one after its release
    function automatic logic [7:0] used_bits(input logic [3:0] a);
        case (a)
            RTCSI_ADDR_CS1: used_bits = 8'hA8;
            RTCSI_ADDR_CS2: used_bits = 8'h1F;
            default: used_bits = 8'hFF;
        endcase
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_acc_busy = 1'b1;
        o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = d & used_bits(a);
        @(negedge i_core_clk);
        o_reg_wr = 1'b0;
        o_acc_busy = 1'b0;
        // released data must not look held
        o_reg_wdata = ~o_reg_wdata;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_acc_busy = 1'b1;
        o_reg_rd = 1'b1;
        o_reg_addr = a;
        @(negedge i_core_clk);
        d = i_reg_rdata;
        o_reg_rd = 1'b0;
        o_acc_busy = 1'b0;
    endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import rtcsi_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic osc = 1'b0;
    logic osc_run = 1'b1;
    logic external_clock_test = 1'b0;
    logic ext_run = 1'b0;
    logic supply_low = 1'b0;
    logic alarm = 1'b0;
    logic tend = 1'b0;
    logic [1:0] src = 2'h0;
    logic [7:0] cnt = 8'h01;
    logic busy, wr, rd;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic carry, por_en, int_o, int_oe_n, sq_o, sq_oe_n;
    int fails = 0;
    int check_count = 0;
    int osc_div = 0;
    logic [31:0] rng = 32'h00011EFE;

    always #2.5 i_core_clk = ~i_core_clk;

    // oscillator pin: 4 core cycles per period; test pin: 2
    always @(negedge i_core_clk)
    begin
        if (osc_run)
        begin
            osc_div <= (osc_div == 1) ? 0 : osc_div + 1;
            if (osc_div == 1)
                osc <= ~osc;
        end
        if (ext_run)
            external_clock_test <= ~external_clock_test;
    end

    rtcsi_host host (.i_core_clk(i_core_clk), .i_reg_rdata(rdata),
        .o_acc_busy(busy), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_addr(addr), .o_reg_wdata(wdata));

    rtcsi_top #(.OSC_STOP_CYCLES(50)) dut (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_osc_in(osc), .i_external_clock_test_test(external_clock_test),
        .i_supply_low(supply_low), .i_acc_busy(busy), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_alarm_match(alarm), .i_timer_end(tend),
        .i_timer_src(src), .i_timer_count(cnt), .o_minute_carry(carry),
        .o_por_override_en(por_en), .o_int_n_o(int_o),
        .o_int_n_oe_n(int_oe_n), .o_square_wave_out_o(sq_o),
        .o_square_wave_out_oe_n(sq_oe_n));

    // =========================================================
    // helpers
    function automatic logic [7:0] rnd8();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction

    // pulse width in oscillator edges
    function automatic int exp_len(input logic [1:0] s, input logic [7:0] c);
        if (s == 2'h0)
            return (c == 8'h01) ? 4 : 8;
        if (s == 2'h1)
            return (c == 8'h01) ? 256 : 512;
        return 512;
    endfunction

    task automatic print_verdict();
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
        input string nm);
        logic [7:0] d;
        host.rd(a, d);
        chk(nm, e, d);
    endtask

    task automatic fire(input logic a, input logic t);
        @(negedge i_core_clk);
        alarm = a;
        tend = t;
        @(negedge i_core_clk);
        alarm = 1'b0;
        tend = 1'b0;
    endtask

    // =========================================================
    // main sequence
    initial
    begin
        logic [7:0] w;
        logic af, tf, alarm_irq_enable, timer_irq_enable;
        int n;
        logic last;
        repeat (2) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_core_clk);
        rd_chk(RTCSI_ADDR_CS1, 8'h08, "cs1_reset");
        rd_chk(RTCSI_ADDR_CS2, 8'h00, "cs2_reset");
        rd_chk(RTCSI_ADDR_SEC, 8'h80, "sec_reset");
        chk("int_idle", 8'h01, 8'(int_oe_n));
        host.wr(4'h7, 8'hFF);
        rd_chk(4'h7, 8'h00, "unmapped");
        host.wr(RTCSI_ADDR_CS1, 8'h80);
        rd_chk(RTCSI_ADDR_CS1, 8'h80, "test_mode");
        chk("por_off", 8'h00, 8'(por_en));
        host.wr(RTCSI_ADDR_CS1, 8'h28);
        rd_chk(RTCSI_ADDR_CS1, 8'h28, "halt_bit");
        n = 0;
        last = sq_oe_n;
        repeat (60)
        begin
            @(negedge i_core_clk);
            if (sq_oe_n !== last)
                n++;
            last = sq_oe_n;
        end
        chk("square_in_halt", 8'h01, 8'(n > 1));
        chk("sq_drive_low", 8'h00, 8'(sq_o));
        host.wr(RTCSI_ADDR_CS1, 8'h08);
        chk("por_on", 8'h01, 8'(por_en));
        host.wr(RTCSI_ADDR_SEC, 8'h59);
        rd_chk(RTCSI_ADDR_SEC, 8'h59, "sec_bcd");
        supply_low = 1'b1;
        repeat (6) @(negedge i_core_clk);
        rd_chk(RTCSI_ADDR_SEC, 8'hD9, "vl_supply");
        host.wr(RTCSI_ADDR_SEC, 8'h00);
        rd_chk(RTCSI_ADDR_SEC, 8'h80, "vl_held");
        supply_low = 1'b0;
        repeat (6) @(negedge i_core_clk);
        host.wr(RTCSI_ADDR_SEC, 8'h00);
        rd_chk(RTCSI_ADDR_SEC, 8'h00, "vl_clear");
        osc_run = 1'b0;
        repeat (100) @(negedge i_core_clk);
        osc_run = 1'b1;
        repeat (6) @(negedge i_core_clk);
        rd_chk(RTCSI_ADDR_SEC, 8'h80, "vl_osc_stop");
        // random flag traffic in level mode
        af = 1'b0;
        tf = 1'b0;
        alarm_irq_enable = 1'b0;
        timer_irq_enable = 1'b0;
        repeat (40)
        begin
            w = rnd8();
            cnt = rnd8() & 8'h03;
            fire(w[7], w[6]);
            af = af | w[7];
            tf = tf | (w[6] & (cnt != 8'h00));
            chk("int_level", 8'(!((af & alarm_irq_enable) | (tf & timer_irq_enable))),
                8'(int_oe_n));
            w[4] = 1'b0;
            host.wr(RTCSI_ADDR_CS2, w);
            af = af & w[3];
            tf = tf & w[2];
            alarm_irq_enable = w[1];
            timer_irq_enable = w[0];
            rd_chk(RTCSI_ADDR_CS2, {4'h0, af, tf, alarm_irq_enable, timer_irq_enable},
                "cs2_flags");
        end
        // pulse widths for every source, n = 1 and n > 1
        for (int s = 0; s < 4; s++)
        begin
            for (int k = 0; k < 2; k++)
            begin
                src = 2'(s);
                cnt = (k == 0) ? 8'h01 : (rnd8() | 8'h02);
                host.wr(RTCSI_ADDR_CS2, 8'h11);
                fire(1'b0, 1'b1);
                chk("pulse_start", 8'h00, 8'(int_oe_n));
                n = 1;
                while (int_oe_n === 1'b0 && n < 12000)
                begin
                    @(negedge i_core_clk);
                    n++;
                end
                if (n >= 12000)
                begin
                    fails++;
                    print_verdict();
                end
                chk("pulse_width", 8'h01,
                    8'(n >= (exp_len(src, cnt) - 1) * 4 &&
                    n <= exp_len(src, cnt) * 4 + 8));
                rd_chk(RTCSI_ADDR_CS2, 8'h15, "pulse_tf");
            end
        end
        // alarm overrides pulse mode
        host.wr(RTCSI_ADDR_CS2, 8'h13);
        fire(1'b1, 1'b0);
        repeat (200) @(negedge i_core_clk);
        chk("alarm_hold", 8'h00, 8'(int_oe_n));
        chk("int_drive_low", 8'h00, 8'(int_o));
        host.wr(RTCSI_ADDR_CS2, 8'h13);
        chk("alarm_cleared", 8'h01, 8'(int_oe_n));
        // one full second on the test pin, halt first to zero the divider
        host.wr(RTCSI_ADDR_SEC, 8'h59);
        host.wr(RTCSI_ADDR_CS1, 8'h28);
        ext_run = 1'b1;
        host.wr(RTCSI_ADDR_CS1, 8'h88);
        n = 0;
        while (carry !== 1'b1 && n < 70000)
        begin
            @(negedge i_core_clk);
            n++;
        end
        chk("minute_carry", 8'h01, 8'(n >= 65530 && n <= 65545));
        rd_chk(RTCSI_ADDR_SEC, 8'h00, "sec_wrap");
        print_verdict();
    end
endmodule
